// File: design/mpp_defines.svh
`ifndef MPP_DEFINES_SVH
`define MPP_DEFINES_SVH

// register byte offsets
`define MPP_OFS_CTRL 8'h00
`define MPP_OFS_PERIOD 8'h04
`define MPP_OFS_STATUS 8'h08

// field positions
`define MPP_CTRL_RUN 0
`define MPP_ST_LIGHT 0
`define MPP_ST_TWO_PHASE 1
`define MPP_ST_COUPLED 2
`define MPP_ST_HOLDOFF 3
`define MPP_ST_PULSE_LO 4

// reset values
`define MPP_CTRL_RST 1'h1
`define MPP_PERIOD_RST 16'h00c8

// timing
`define MPP_CLK_KHZ 200000
`define MPP_HOLDOFF_MS 50
`define MPP_STRAP_SETTLE 2'h2

`endif

// File: design/mpp_pkg.sv
package mpp_pkg;
  typedef enum logic [1:0] {PS_NORMAL, PS_HOLDOFF, PS_LIGHT} mpp_pstate_type;
  typedef logic [31:0] mpp_word_type;
  typedef logic [15:0] mpp_period_type;
endpackage

// File: design/mpp_chan_if.sv
`timescale 1ns/1ps
interface mpp_chan_if (
  input wire logic clock,
  input wire logic rst
);
  logic intervalStart;
  logic aboveRamp;
  logic forceOn;
  logic enable;
  logic demMode;
  logic zeroCurrent;
  logic pulseNow;
  logic upperDrive;
  logic lowerDrive;

  modport ctrl (
    input clock, rst, pulseNow, upperDrive, lowerDrive,
    output intervalStart, aboveRamp, forceOn, enable, demMode, zeroCurrent
  );
  modport chan (
    input clock, rst, intervalStart, aboveRamp, forceOn, enable, demMode, zeroCurrent,
    output pulseNow, upperDrive, lowerDrive
  );
endinterface

// File: design/mpp_channel.sv
`timescale 1ns/1ps
module mpp_channel (
  // control and drive
  mpp_chan_if.chan bus
);
  logic aboveDly_ff;
  logic armed_ff;
  logic pulse_ff;
  logic zeroSeen_ff;
  logic upper_ff;
  logic lower_ff;
  logic nxt_pulse;
  logic nxt_armed;
  logic nxt_zeroSeen;
  logic armNow;
  logic riseReq;
  logic setPulse;
  logic zeroBlock;

  // a rise is only honoured while armed within the interval
  assign armNow = armed_ff | bus.intervalStart;
  // level is compared afresh at each interval start, not only on an edge
  assign riseReq = bus.aboveRamp & (~aboveDly_ff | bus.intervalStart);
  assign setPulse = armNow & riseReq;
  // high until the level drops back under the ramp
  assign nxt_pulse = bus.enable & (bus.forceOn | setPulse | (pulse_ff & bus.aboveRamp));
  assign nxt_armed = armNow & ~setPulse & ~bus.forceOn;
  // zero current seen: keep both switches off until the next interval
  assign nxt_zeroSeen = bus.demMode & (bus.zeroCurrent | (zeroSeen_ff & ~bus.intervalStart));
  assign zeroBlock = bus.demMode & nxt_zeroSeen;

  always_ff @(posedge bus.clock) begin
    if (bus.rst) begin
      aboveDly_ff <= 1'b0;
      armed_ff <= 1'b0;
      pulse_ff <= 1'b0;
      zeroSeen_ff <= 1'b0;
      upper_ff <= 1'b0;
      lower_ff <= 1'b0;
    end else begin
      aboveDly_ff <= bus.aboveRamp;
      armed_ff <= nxt_armed;
      pulse_ff <= nxt_pulse;
      zeroSeen_ff <= nxt_zeroSeen;
      upper_ff <= nxt_pulse & ~zeroBlock;
      lower_ff <= bus.enable & ~nxt_pulse & ~zeroBlock;
    end
  end

  assign bus.pulseNow = pulse_ff;
  assign bus.upperDrive = upper_ff;
  assign bus.lowerDrive = lower_ff;
endmodule // mpp_channel

// File: design/mpp_pwm_top.sv
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "mpp_defines.svh"
module mpp_pwm_top #(
  parameter bit DIODE_EMU = 1'b1,
  parameter bit HAS_CPU_RESET = 1'b1,
  parameter int unsigned HOLDOFF_CYCLES = `MPP_HOLDOFF_MS * `MPP_CLK_KHZ,
  parameter int NUM_CH = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // comparator results per channel
  input wire logic [2:0] aboveRampRaw,
  input wire logic allPhaseAlign,
  input wire logic ch1ZeroCurrent,
  // straps
  input wire logic ch3SenseNeg,
  input wire logic freqSelectStrap,
  // power state control
  input wire logic powerStateLowN,
  input wire logic cpuResetHoldN,
  input wire logic softStartBusy,
  input wire logic codeTransitionBusy,
  // gate driver outputs
  output logic [2:0] upperSwitchDrive,
  output logic [2:0] lowerSwitchDrive,
  output logic gateDriveReduction,
  output logic coupledInductorMode,
  output logic lightState
);
  localparam int SYNC_W = 11;
  localparam logic [23:0] HOLD_LAST = 24'(HOLDOFF_CYCLES - 1);

  // synchroniser stages
  logic [SYNC_W-1:0] syncA_ff;
  logic [SYNC_W-1:0] syncB_ff;
  logic [SYNC_W-1:0] asyncIn;
  logic [2:0] aboveRamp;
  logic alignSync;
  logic zeroSync;
  logic ch3Sync;
  logic fsSync;
  logic psiNSync;
  logic cpuNSync;
  logic ssSync;
  logic codeSync;

  // registers
  logic runEn_ff;
  mpp_pkg::mpp_period_type period_ff;
  logic [31:0] prdata_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [1:0] cfgCnt_ff;
  logic twoPhase_ff;
  logic coupled_ff;
  mpp_pkg::mpp_pstate_type state_ff;
  mpp_pkg::mpp_pstate_type nxt_state;
  logic [23:0] hold_ff;
  logic [23:0] nxt_hold;
  logic cpuPrev_ff;
  logic lightApplied_ff;
  logic nxt_lightApplied;
  logic gateRed_ff;

  // decode
  logic setup;
  logic access;
  logic wrEn;
  logic selCtrl;
  logic selPeriod;
  logic selStatus;
  logic mapped;
  logic [31:0] rdMux;
  logic [31:0] statusWord;
  logic boundary;
  logic blocked;
  logic cpuRise;
  logic [2:0] chStart;
  logic [2:0] chEnable;
  logic [2:0] pulses;
  logic [2:0] ups;
  logic [2:0] lows;
  logic [15:0] third;
  logic [15:0] half;

  // offset of a channel's interval start inside the period
  function automatic logic [15:0] phaseOffset(input int idx, input logic twoPh,
                                              input logic [15:0] t, input logic [15:0] h);
    logic [15:0] r;
    r = 16'h0000;
    if (idx == 1) begin
      r = twoPh ? h : t;
    end else if (idx == 2) begin
      r = 16'(t + t);
    end
    return r;
  endfunction

  // all comparator, strap and power state inputs pass two flip-flops
  assign asyncIn = {aboveRampRaw, allPhaseAlign, ch1ZeroCurrent, ch3SenseNeg,
                    freqSelectStrap, powerStateLowN, cpuResetHoldN, softStartBusy,
                    codeTransitionBusy};

  always_ff @(posedge clock) begin
    if (rst) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= asyncIn;
      syncB_ff <= syncA_ff;
    end
  end

  assign aboveRamp = syncB_ff[10:8];
  assign alignSync = syncB_ff[7];
  assign zeroSync = syncB_ff[6];
  assign ch3Sync = syncB_ff[5];
  assign fsSync = syncB_ff[4];
  assign psiNSync = syncB_ff[3];
  assign cpuNSync = syncB_ff[2];
  assign ssSync = syncB_ff[1];
  assign codeSync = syncB_ff[0];

  // apb decode
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign selCtrl = paddr == `MPP_OFS_CTRL;
  assign selPeriod = paddr == `MPP_OFS_PERIOD;
  assign selStatus = paddr == `MPP_OFS_STATUS;
  assign mapped = selCtrl | selPeriod | selStatus;
  assign wrEn = access & pwrite & mapped;
  assign statusWord = {25'h0000000, pulses, (state_ff == mpp_pkg::PS_HOLDOFF),
                       coupledInductorMode, twoPhase_ff, lightApplied_ff};
  assign rdMux = selCtrl ? {31'h00000000, runEn_ff} :
                 selPeriod ? {16'h0000, period_ff} :
                 selStatus ? statusWord : 32'h00000000;
  assign pready = access;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      runEn_ff <= `MPP_CTRL_RST;
      period_ff <= `MPP_PERIOD_RST;
      prdata_ff <= 32'h00000000;
    end else begin
      if (wrEn & selCtrl) begin
        runEn_ff <= pwdata[`MPP_CTRL_RUN];
      end
      if (wrEn & selPeriod) begin
        period_ff <= pwdata[15:0];
      end
      if (setup) begin
        prdata_ff <= rdMux;
      end
    end
  end

  // interval counter and interleaved starts
  assign boundary = cnt_ff == 16'h0000;
  assign nxt_cnt = (cnt_ff >= 16'(period_ff - 16'h0001)) ? 16'h0000 : 16'(cnt_ff + 16'h0001);
  assign third = period_ff / 16'h0003;
  assign half = period_ff >> 1;

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // straps are caught once after the synchronisers settle
  always_ff @(posedge clock) begin
    if (rst) begin
      cfgCnt_ff <= 2'h0;
      twoPhase_ff <= 1'b0;
      coupled_ff <= 1'b0;
    end else begin
      if (cfgCnt_ff != 2'h3) begin
        cfgCnt_ff <= 2'(cfgCnt_ff + 2'h1);
      end
      if (cfgCnt_ff == `MPP_STRAP_SETTLE) begin
        twoPhase_ff <= ch3Sync;
        coupled_ff <= fsSync;
      end
    end
  end

  assign coupledInductorMode = DIODE_EMU & coupled_ff;

  // power state machine
  assign blocked = ssSync | codeSync | (HAS_CPU_RESET & ~cpuNSync);
  assign cpuRise = HAS_CPU_RESET & cpuNSync & ~cpuPrev_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_hold = hold_ff;
    if (cpuRise) begin
      nxt_state = mpp_pkg::PS_HOLDOFF;
      nxt_hold = 24'h000000;
    end else begin
      case (state_ff)
        mpp_pkg::PS_NORMAL: begin
          if (~blocked & ~psiNSync) begin
            nxt_state = mpp_pkg::PS_LIGHT;
          end
        end
        mpp_pkg::PS_HOLDOFF: begin
          if (HAS_CPU_RESET & ~cpuNSync) begin
            nxt_state = mpp_pkg::PS_NORMAL;
          end else if (hold_ff >= HOLD_LAST) begin
            nxt_state = mpp_pkg::PS_NORMAL;
          end else begin
            nxt_hold = 24'(hold_ff + 24'h000001);
          end
        end
        mpp_pkg::PS_LIGHT: begin
          if (blocked | psiNSync) begin
            nxt_state = mpp_pkg::PS_NORMAL;
          end
        end
        default: begin
          nxt_state = mpp_pkg::PS_NORMAL;
        end
      endcase
    end
  end

  // entry waits for a boundary, exit is immediate
  assign nxt_lightApplied = (nxt_state == mpp_pkg::PS_LIGHT) &
                            (lightApplied_ff | boundary);

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= mpp_pkg::PS_NORMAL;
      hold_ff <= 24'h000000;
      cpuPrev_ff <= 1'b0;
      lightApplied_ff <= 1'b0;
      gateRed_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      hold_ff <= nxt_hold;
      cpuPrev_ff <= cpuNSync;
      lightApplied_ff <= nxt_lightApplied;
      gateRed_ff <= DIODE_EMU & nxt_lightApplied;
    end
  end

  assign lightState = lightApplied_ff;
  assign gateDriveReduction = gateRed_ff;

  // channel enables follow run: channel one kept, others shed in light state, channel three also off in two-phase
  assign chEnable[0] = runEn_ff;
  assign chEnable[1] = runEn_ff & ~lightApplied_ff;
  assign chEnable[2] = runEn_ff & ~lightApplied_ff & ~twoPhase_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      mpp_chan_if chIf (
        .clock(clock),
        .rst(rst)
      );
      assign chStart[gi] = cnt_ff == phaseOffset(gi, twoPhase_ff, third, half);
      assign chIf.intervalStart = chStart[gi];
      assign chIf.aboveRamp = aboveRamp[gi];
      assign chIf.forceOn = alignSync;
      assign chIf.enable = chEnable[gi];
      assign chIf.demMode = (gi == 0) & DIODE_EMU & lightApplied_ff;
      assign chIf.zeroCurrent = (gi == 0) & zeroSync;
      assign pulses[gi] = chIf.pulseNow;
      assign ups[gi] = chIf.upperDrive;
      assign lows[gi] = chIf.lowerDrive;
      mpp_channel u_ch (
        .bus(chIf.chan)
      );
    end
  endgenerate

  assign upperSwitchDrive = ups;
  assign lowerSwitchDrive = lows;
endmodule // mpp_pwm_top

// File: bench/mpp_pwm_top_chk.sv
`timescale 1ns/1ps
module mpp_pwm_top_chk #(
  parameter bit DIODE_EMU = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched inputs
  input wire logic allPhaseAlign,
  input wire logic powerStateLowN,
  input wire logic cpuResetHoldN,
  input wire logic softStartBusy,
  input wire logic codeTransitionBusy,
  // watched outputs
  input wire logic [2:0] upperSwitchDrive,
  input wire logic [2:0] lowerSwitchDrive,
  input wire logic gateDriveReduction,
  input wire logic lightState
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_overlap; (upperSwitchDrive & lowerSwitchDrive) == 3'h0; endproperty
  a_overlap: assert property (p_overlap) else $error("both switches on");
  property p_shed; lightState [*3] |-> {upperSwitchDrive[2:1], lowerSwitchDrive[2:1]} == 4'h0;
  endproperty
  a_shed: assert property (p_shed) else $error("shed channel switching");
  property p_gdr; $stable(lightState) |-> gateDriveReduction == (lightState && DIODE_EMU);
  endproperty
  a_gdr: assert property (p_gdr) else $error("drive level wrong");
  property p_exit; powerStateLowN [*5] |-> !lightState; endproperty
  a_exit: assert property (p_exit) else $error("light state kept");
  property p_cpu; !cpuResetHoldN [*5] |-> !lightState; endproperty
  a_cpu: assert property (p_cpu) else $error("light during cpu reset");
  property p_busy; (softStartBusy || codeTransitionBusy) [*5] |-> !lightState; endproperty
  a_busy: assert property (p_busy) else $error("light while busy");
  property p_hold; $rose(cpuResetHoldN) |=> !lightState [*8]; endproperty
  a_hold: assert property (p_hold) else $error("light too early");
  property p_align; allPhaseAlign [*5] |-> upperSwitchDrive[0]; endproperty
  a_align: assert property (p_align) else $error("align not forced");
endmodule // mpp_pwm_top_chk
bind mpp_pwm_top mpp_pwm_top_chk #(.DIODE_EMU(DIODE_EMU)) mpp_pwm_top_chk_inst (
  .clock, .rst, .allPhaseAlign, .powerStateLowN, .cpuResetHoldN, .softStartBusy,
  .codeTransitionBusy, .upperSwitchDrive, .lowerSwitchDrive, .gateDriveReduction, .lightState
);

// File: bench/mpp_gate_drv.sv
`timescale 1ns/1ps
module mpp_gate_drv (
  // drive inputs
  input wire logic clock,
  input wire logic [2:0] upper,
  // upper rise counts
  output int rises [3]
);
  logic [2:0] lastUp = 3'h0;
  initial rises = '{0, 0, 0};
  // count upper switch turn-on edges per channel
  always @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (upper[i] && !lastUp[i]) rises[i] <= rises[i] + 1;
    end
    lastUp <= upper;
  end
endmodule // mpp_gate_drv

// File: bench/test_multiphase_pwm_power_state.sv
`timescale 1ns/1ps
`include "mpp_defines.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module test_multiphase_pwm_power_state;
  localparam logic [31:0] P = 32'h1e;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, allPhaseAlign = 1'b0, ch1ZeroCurrent = 1'b0, ch3SenseNeg = 1'b0;
  logic freqSelectStrap = 1'b1, powerStateLowN = 1'b1, cpuResetHoldN = 1'b1;
  logic softStartBusy = 1'b0, codeTransitionBusy = 1'b0;
  logic [2:0] aboveRampRaw = 3'h0, upperSwitchDrive, lowerSwitchDrive;
  logic gateDriveReduction, coupledInductorMode, lightState;
  int rises [3];
  int n_fail = 0, cmp_count = 0, cycles = 0;
  mpp_pwm_top #(.HOLDOFF_CYCLES(20)) mpp_pwm_top_inst (.clock, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .aboveRampRaw, .allPhaseAlign,
    .ch1ZeroCurrent, .ch3SenseNeg, .freqSelectStrap, .powerStateLowN, .cpuResetHoldN,
    .softStartBusy, .codeTransitionBusy, .upperSwitchDrive, .lowerSwitchDrive,
    .gateDriveReduction, .coupledInductorMode, .lightState);
  mpp_gate_drv mpp_gate_drv_inst (.clock, .upper(upperSwitchDrive), .rises);
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    `CHK(pslverr, e);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic pulses(input logic [2:0] m);
    int r0 [3];
    int d;
    r0 = rises;
    repeat (4 * P) begin
      @(posedge clock);
      aboveRampRaw <= ~aboveRampRaw;
    end
    for (int i = 0; i < 3; i++) begin
      d = rises[i] - r0[i];
      `CHK(m[i] ? (d == 4 || d == 5) : (d == 0), 1'b1);
    end
  endtask
  task automatic restart;
    rst <= 1'b1;
    tick(5);
    rst <= 1'b0;
    tick(5);
    apb(1'b1, `MPP_OFS_PERIOD, P, 1'b0);
  endtask
  initial begin
    restart();
    apb(1'b0, `MPP_OFS_CTRL, 32'h0, 1'b0);
    `CHK(r, 32'h1);
    apb(1'b0, `MPP_OFS_PERIOD, 32'h0, 1'b0);
    `CHK(r, P);
    apb(1'b0, 8'h0c, 32'h0, 1'b1);
    `CHK(r, 32'h0);
    `CHK(coupledInductorMode, 1'b1);
    pulses(3'h7);
    aboveRampRaw <= 3'h0;
    tick(6);
    `CHK({upperSwitchDrive, lowerSwitchDrive}, 6'h07);
    aboveRampRaw <= 3'h7;
    tick(P + 6);
    `CHK({upperSwitchDrive, lowerSwitchDrive}, 6'h38);
    aboveRampRaw <= 3'h0;
    tick(6);
    `CHK(upperSwitchDrive, 3'h0);
    allPhaseAlign <= 1'b1;
    tick(6);
    `CHK(upperSwitchDrive, 3'h7);
    allPhaseAlign <= 1'b0;
    powerStateLowN <= 1'b0;
    tick(2 * P);
    `CHK({lightState, gateDriveReduction}, 2'h3);
    apb(1'b0, `MPP_OFS_STATUS, 32'h0, 1'b0);
    `CHK(r[2:0], 3'h5);
    pulses(3'h1);
    aboveRampRaw <= 3'h0;
    tick(6);
    ch1ZeroCurrent <= 1'b1;
    tick(6);
    `CHK({upperSwitchDrive[0], lowerSwitchDrive[0]}, 2'h0);
    ch1ZeroCurrent <= 1'b0;
    powerStateLowN <= 1'b1;
    tick(5);
    `CHK(lightState, 1'b0);
    softStartBusy <= 1'b1;
    powerStateLowN <= 1'b0;
    tick(2 * P);
    `CHK(lightState, 1'b0);
    softStartBusy <= 1'b0;
    tick(2 * P);
    `CHK(lightState, 1'b1);
    codeTransitionBusy <= 1'b1;
    tick(6);
    `CHK(lightState, 1'b0);
    codeTransitionBusy <= 1'b0;
    cpuResetHoldN <= 1'b0;
    tick(2 * P);
    `CHK(lightState, 1'b0);
    cpuResetHoldN <= 1'b1;
    tick(14);
    `CHK(lightState, 1'b0);
    tick(2 * P + 10);
    `CHK(lightState, 1'b1);
    powerStateLowN <= 1'b1;
    ch3SenseNeg <= 1'b1;
    restart();
    apb(1'b0, `MPP_OFS_STATUS, 32'h0, 1'b0);
    `CHK(r[1], 1'b1);
    pulses(3'h3);
    apb(1'b1, `MPP_OFS_CTRL, 32'h0, 1'b0);
    tick(6);
    `CHK({upperSwitchDrive, lowerSwitchDrive}, 6'h00);
    close_out();
  end
endmodule // test_multiphase_pwm_power_state
